/* design/opmode_pkg.sv */
package opmode_pkg;

  localparam int NCH = 4;
  localparam int NIN = 2;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_OUT = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_HWCR = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_MAP0 = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_MAP1 = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_STAT = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_DIAG = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_ERR = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_OSM = 8'h1C;

  // field positions
  localparam int KEEP_ACTIVE_BIT_BIT = 0;
  localparam int SOFT_RESET_BIT_BIT = 1;
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_UV_BIT = 2;
  localparam int STAT_LOP_BIT = 3;
  localparam int STAT_TER_BIT = 4;

  // reset values, plus the limp home channel mask
  localparam logic [NCH-1:0] OUT_RST = 4'h0;
  localparam logic [NCH-1:0] MAP0_RST = 4'h4;
  localparam logic [NCH-1:0] MAP1_RST = 4'h8;
  localparam logic [NCH-1:0] OPEN_LOAD_OFF_TEST_BIT_RST = 4'h0;
  localparam logic [NCH-1:0] ERR_RST = 4'h0;
  localparam logic [NCH-1:0] LIMP_CH_MASK = 4'hC;

  // mode codes as software sees them
  localparam logic [1:0] MS_IDLE = 2'h0;
  localparam logic [1:0] MS_LIMP = 2'h1;
  localparam logic [1:0] MS_ACTIVE = 2'h2;
  localparam logic [1:0] MS_SLEEP = 2'h3;

  // mode transition latency
  localparam int CLK_MHZ = 25;
  localparam int MODE_LAT_NS = 2000;
  localparam int MODE_LAT_CYC = (MODE_LAT_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [1:0] {
    ST_SLEEP = 2'h0,
    ST_IDLE = 2'h1,
    ST_ACTIVE = 2'h3,
    ST_LIMP = 2'h2
  } mode_e;

  typedef struct packed {
    logic wake;
    logic [NIN-1:0] din;
    logic [NCH-1:0] fault;
    logic [NCH-1:0] osm;
  } pins_s;

  typedef struct packed {
    logic vs_uv;
    logic vs_op_ok;
    logic vdd_ok;
    logic vdd_lop;
  } supply_s;

  typedef struct packed {
    mode_e mode;
    logic [NCH-1:0] chan_on;
    logic keep_act;
    logic [NCH-1:0] map0;
    logic [NCH-1:0] map1;
    logic [NCH-1:0] open_load_off_test_bit;
    logic [NCH-1:0] err;
    logic [NCH-1:0] out;
    logic uv_f;
    logic lop_f;
    logic ter_f;
    logic ter_first;
    logic [DATA_W-1:0] rdata;
    logic slverr;
    logic pwr_on;
  } ctl_s;

endpackage

/* design/sync2.sv */
`timescale 1ns/100ps
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // first stage feeds only the second stage
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule
`default_nettype wire

/* design/mode_latency_timer.sv */
`timescale 1ns/100ps
`default_nettype none
module mode_latency_timer #(
  parameter int CYC = 50,
  parameter int CW = 16
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic run,
  output logic done
);
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  localparam logic [CW-1:0] LAST = CW'(CYC - 1);

  // dropping run restarts the wait, so a withdrawn request costs nothing
  always_comb begin
    cnt_d = cnt_q;
    if (!run) begin
      cnt_d = '0;
    end else if (cnt_q != LAST) begin
      cnt_d = cnt_q + CW'(1);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign done = run && (cnt_q == LAST);
endmodule
`default_nettype wire

/* design/operation_mode_controller.sv */
// Summary of operation
// RL1: sleep keeps all channels off and all registers at reset values
// RL2: idle keeps channels off and runs no diagnosis
// RL3: idle with digital supply present keeps registers working and accepts access
// RL4: idle never clears the latched channel error bits
// RL5: wake high plus any input or channel-on bit enters active
// RL6: keep-active clear: active drops to idle once inputs and on bits are zero
// RL7: keep-active set: active holds regardless of inputs and on bits
// RL8: digital undervoltage moves active to idle when all inputs are low
// RL9: a high input enters active even when both input maps are zero
// RL10: wake low with any input high enters limp home, driving its channel
// RL11: limp home answers reads but ignores every write
// RL12: limp home reports analog-undervoltage and digital-low-power flags as one
// RL13: limp home shows mode code 01 and forces open-load-off bits to zero
// RL14: first access after entering limp home reads transmission error as one
// RL15: limp home keeps error bits and output monitor bits working
// RL16: all other registers stay at defaults and refuse writes in limp home
// RL17: limp home drives only channels 2 and 3 from inputs
// RL18: host avoids accesses while moving between active and limp home
// RL19: power-on needs a supply over threshold and wake or an input high
// RL20: turn-on from sleep or idle waits the mode latency first
// RL21: undervoltage, low wake or soft reset restore defaults; errors kept
// RL22: mode evaluated synchronously, updated once per clock cycle
`timescale 1ns/100ps
`default_nettype none
module operation_mode_controller #(
  parameter int LAT_CYC = opmode_pkg::MODE_LAT_CYC
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire opmode_pkg::pins_s pins,
  input wire opmode_pkg::supply_s supply,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [opmode_pkg::ADDR_W-1:0] paddr,
  input wire logic [opmode_pkg::DATA_W-1:0] pwdata,
  output logic [opmode_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [opmode_pkg::NCH-1:0] channel_out,
  output logic [opmode_pkg::NCH-1:0] open_load_test,
  output opmode_pkg::mode_e op_mode,
  output logic power_on
);
  import opmode_pkg::*;

  logic rst_meta_q;
  logic rst_n;
  pins_s pin_s;
  supply_s sup_s;
  ctl_s q;
  ctl_s d;
  logic any_in;
  logic pwr_cond;
  logic lat_run;
  logic lat_done;
  mode_e target;
  logic setup;
  logic access;
  logic comm_ok;
  logic wr_ok;
  logic soft_rst;
  logic regs_clr;
  logic stat_rd;
  logic mapped;

  // route each input to the channels its map selects
  function automatic logic [NCH-1:0] map_inputs(
    input logic [NIN-1:0] din,
    input logic [NCH-1:0] m0,
    input logic [NCH-1:0] m1
  );
    map_inputs = ({NCH{din[0]}} & m0) | ({NCH{din[1]}} & m1);
  endfunction

  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    addr_mapped = (a == OFF_OUT) || (a == OFF_HWCR) || (a == OFF_MAP0) ||
                  (a == OFF_MAP1) || (a == OFF_STAT) || (a == OFF_DIAG) ||
                  (a == OFF_ERR) || (a == OFF_OSM);
  endfunction

  // reset released through two flops
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  sync2 #(
    .W($bits(pins_s))
  ) u_pin_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in(pins),
    .sync_out(pin_s)
  );

  sync2 #(
    .W($bits(supply_s))
  ) u_sup_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in(supply),
    .sync_out(sup_s)
  );

  mode_latency_timer #(
    .CYC(LAT_CYC)
  ) u_lat (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .run(lat_run),
    .done(lat_done)
  );

  assign any_in = |pin_s.din;
  // either supply over its operating threshold, plus wake or an input
  assign pwr_cond = (sup_s.vs_op_ok || (sup_s.vdd_ok && !sup_s.vdd_lop)) &&
                    (pin_s.wake || any_in); // RL19

  // mode the pins and bits currently ask for
  always_comb begin
    target = ST_SLEEP;
    if (!pwr_cond) begin
      target = ST_SLEEP;
    end else if (!pin_s.wake) begin
      target = any_in ? ST_LIMP : ST_SLEEP; // RL10
    end else if (any_in) begin
      target = ST_ACTIVE; // RL5 RL9
    end else if (!sup_s.vdd_ok) begin
      target = ST_IDLE; // RL8
    end else if (|q.chan_on) begin
      target = ST_ACTIVE; // RL5
    end else if (q.mode == ST_ACTIVE && q.keep_act) begin
      target = ST_ACTIVE; // RL7
    end else begin
      target = ST_IDLE; // RL6
    end
  end

  // leaving sleep or idle for a driving mode costs the wake-up latency
  assign lat_run = (q.mode == ST_SLEEP || q.mode == ST_IDLE) &&
                   (target == ST_ACTIVE || target == ST_LIMP); // RL20

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign comm_ok = sup_s.vdd_ok && (q.mode != ST_SLEEP); // RL3
  assign wr_ok = comm_ok && (q.mode != ST_LIMP); // RL11 RL16
  assign soft_rst = access && pwrite && wr_ok && (paddr == OFF_HWCR) &&
                    pwdata[SOFT_RESET_BIT_BIT];
  assign stat_rd = access && !pwrite && comm_ok && (paddr == OFF_STAT);
  assign mapped = addr_mapped(paddr);
  // limp home implies wake low, so this also holds limp registers at default
  assign regs_clr = (q.mode == ST_SLEEP) || !sup_s.vdd_ok || !pin_s.wake ||
                    soft_rst; // RL1 RL16 RL21

  always_comb begin
    d = q;
    d.pwr_on = pwr_cond; // RL19

    // mode update, one step per clock
    if (target != q.mode) begin // RL22
      if (!lat_run || lat_done) begin
        d.mode = target;
      end
    end

    // configuration writes
    if (access && pwrite && wr_ok) begin
      if (paddr == OFF_OUT) begin
        d.chan_on = pwdata[NCH-1:0];
      end else if (paddr == OFF_HWCR) begin
        d.keep_act = pwdata[KEEP_ACTIVE_BIT_BIT];
      end else if (paddr == OFF_MAP0) begin
        d.map0 = pwdata[NCH-1:0];
      end else if (paddr == OFF_MAP1) begin
        d.map1 = pwdata[NCH-1:0];
      end else if (paddr == OFF_DIAG) begin
        d.open_load_off_test_bit = pwdata[NCH-1:0];
      end
    end

    if (regs_clr) begin
      d.chan_on = OUT_RST;
      d.keep_act = 1'b0;
      d.map0 = MAP0_RST;
      d.map1 = MAP1_RST;
      d.open_load_off_test_bit = OPEN_LOAD_OFF_TEST_BIT_RST; // RL13
    end

    // channel errors: write one to clear, a new fault wins
    if (access && pwrite && wr_ok && paddr == OFF_ERR) begin
      d.err = q.err & ~pwdata[NCH-1:0];
    end
    if (q.mode == ST_ACTIVE || q.mode == ST_LIMP) begin
      d.err = d.err | pin_s.fault; // RL15 RL2
    end
    if (q.mode == ST_SLEEP) begin
      d.err = ERR_RST; // RL1
    end
    // idle and soft reset leave err untouched RL4 RL21

    // supply flags clear on a status read once the condition is gone
    if (stat_rd && !sup_s.vs_uv) begin
      d.uv_f = 1'b0;
    end
    if (stat_rd && !sup_s.vdd_lop) begin
      d.lop_f = 1'b0;
    end
    if (soft_rst || q.mode == ST_SLEEP) begin
      d.uv_f = 1'b0; // RL21
      d.lop_f = 1'b0;
    end
    if (q.mode != ST_SLEEP && sup_s.vs_uv) begin
      d.uv_f = 1'b1;
    end
    if (q.mode != ST_SLEEP && sup_s.vdd_lop) begin
      d.lop_f = 1'b1;
    end

    // transmission error: unmapped access sets, status read clears
    if (stat_rd) begin
      d.ter_f = 1'b0;
    end
    if (access && comm_ok && !mapped) begin
      d.ter_f = 1'b1;
    end
    if (access) begin
      d.ter_first = 1'b0;
    end
    if (d.mode == ST_LIMP && q.mode != ST_LIMP) begin
      d.ter_first = 1'b1; // RL14
    end
    if (q.mode == ST_SLEEP) begin
      d.ter_f = 1'b0;
    end

    // read data captured in setup, shown in the access cycle
    if (setup) begin
      d.rdata = '0;
      d.slverr = comm_ok && !mapped;
      if (!comm_ok || pwrite) begin
        d.rdata = '0;
      end else if (paddr == OFF_OUT) begin
        d.rdata[NCH-1:0] = q.chan_on;
      end else if (paddr == OFF_HWCR) begin
        d.rdata[KEEP_ACTIVE_BIT_BIT] = q.keep_act;
      end else if (paddr == OFF_MAP0) begin
        d.rdata[NCH-1:0] = q.map0;
      end else if (paddr == OFF_MAP1) begin
        d.rdata[NCH-1:0] = q.map1;
      end else if (paddr == OFF_STAT) begin
        if (q.mode == ST_LIMP) begin
          d.rdata[STAT_MODE_LSB +: 2] = MS_LIMP; // RL13
        end else if (q.mode == ST_ACTIVE) begin
          d.rdata[STAT_MODE_LSB +: 2] = MS_ACTIVE;
        end else begin
          d.rdata[STAT_MODE_LSB +: 2] = MS_IDLE;
        end
        d.rdata[STAT_UV_BIT] = q.uv_f || (q.mode == ST_LIMP); // RL12
        d.rdata[STAT_LOP_BIT] = q.lop_f || (q.mode == ST_LIMP); // RL12
        d.rdata[STAT_TER_BIT] = q.ter_f || q.ter_first; // RL14
      end else if (paddr == OFF_DIAG) begin
        d.rdata[NCH-1:0] = (q.mode == ST_LIMP) ? OPEN_LOAD_OFF_TEST_BIT_RST : q.open_load_off_test_bit; // RL13
      end else if (paddr == OFF_ERR) begin
        d.rdata[NCH-1:0] = q.err; // RL15
      end else if (paddr == OFF_OSM) begin
        d.rdata[NCH-1:0] = pin_s.osm; // RL15
      end
    end

    // channel drive
    if (q.mode == ST_ACTIVE) begin
      d.out = map_inputs(pin_s.din, q.map0, q.map1);
      if (sup_s.vdd_ok) begin
        d.out = d.out | q.chan_on;
      end
    end else if (q.mode == ST_LIMP) begin
      // limp uses the default maps, whatever was programmed before
      d.out = map_inputs(pin_s.din, MAP0_RST, MAP1_RST) & LIMP_CH_MASK; // RL17
    end else begin
      d.out = '0; // RL1 RL2
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{
        mode: ST_SLEEP,
        chan_on: OUT_RST,
        keep_act: 1'b0,
        map0: MAP0_RST,
        map1: MAP1_RST,
        open_load_off_test_bit: OPEN_LOAD_OFF_TEST_BIT_RST,
        err: ERR_RST,
        out: '0,
        uv_f: 1'b0,
        lop_f: 1'b0,
        ter_f: 1'b0,
        ter_first: 1'b0,
        rdata: '0,
        slverr: 1'b0,
        pwr_on: 1'b0
      };
    end else begin
      q <= d;
    end
  end

  // zero-wait slave: read data was fetched during setup
  assign pready = 1'b1;
  assign prdata = q.rdata;
  assign pslverr = q.slverr && access;
  assign channel_out = q.out;
  // open-load test only runs where diagnosis exists
  assign open_load_test = (q.mode == ST_ACTIVE) ? q.open_load_off_test_bit : OPEN_LOAD_OFF_TEST_BIT_RST; // RL2
  assign op_mode = q.mode;
  assign power_on = q.pwr_on;
endmodule
`default_nettype wire

/* dv/operation_mode_controller_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module operation_mode_controller_checker #(
  parameter int LAT_CYC = opmode_pkg::MODE_LAT_CYC
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire opmode_pkg::pins_s pins,
  input wire opmode_pkg::supply_s supply,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [opmode_pkg::ADDR_W-1:0] paddr,
  input wire logic [opmode_pkg::DATA_W-1:0] pwdata,
  input wire logic [opmode_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [opmode_pkg::NCH-1:0] channel_out,
  input wire logic [opmode_pkg::NCH-1:0] open_load_test,
  input wire opmode_pkg::mode_e op_mode,
  input wire logic power_on
);
  import opmode_pkg::*;
  logic rd_acc;
  assign rd_acc = psel && penable && !pwrite;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // drive lags the mode by one cycle, so wait for a settled mode
  a_sleep_chan_off: assert property (
    $stable(op_mode) && op_mode == ST_SLEEP |-> channel_out == 4'h0)
    else $error("channel on in sleep");
  a_idle_chan_off: assert property (
    $stable(op_mode) && op_mode == ST_IDLE |-> channel_out == 4'h0)
    else $error("channel on in idle");
  a_limp_chan_mask: assert property (
    $stable(op_mode) && op_mode == ST_LIMP |-> (channel_out & ~LIMP_CH_MASK) == 4'h0)
    else $error("limp drives a locked channel");
  a_limp_ol_off: assert property (
    op_mode == ST_LIMP && $past(op_mode) == ST_LIMP |-> open_load_test == 4'h0)
    else $error("open-load test on in limp");
  a_sleep_read_zero: assert property (
    rd_acc && op_mode == ST_SLEEP && $past(op_mode) == ST_SLEEP |-> prdata == 32'h0)
    else $error("sleep read not zero");
  a_limp_stat_flags: assert property (
    rd_acc && paddr == OFF_STAT && op_mode == ST_LIMP && $past(op_mode) == ST_LIMP
    |-> prdata[3:0] == 4'hD)
    else $error("limp status flags wrong");
  a_entry_latency: assert property (
    $changed(op_mode) && op_mode == ST_ACTIVE && $past(op_mode) != ST_LIMP
    |-> $past(op_mode, LAT_CYC) == $past(op_mode))
    else $error("active entered before latency");
  a_power_sleep: assert property (
    $fell(power_on) |-> ##[0:2] op_mode == ST_SLEEP)
    else $error("no sleep after power loss");
  c_active: cover property (op_mode == ST_ACTIVE);
  c_limp: cover property (op_mode == ST_LIMP);
  c_unmapped: cover property (pslverr);
endmodule
bind operation_mode_controller operation_mode_controller_checker #(.LAT_CYC(LAT_CYC)) i_chk (
  .core_clk(core_clk), .reset_n(reset_n), .pins(pins), .supply(supply), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .channel_out(channel_out),
  .open_load_test(open_load_test), .op_mode(op_mode), .power_on(power_on));
`default_nettype wire

/* dv/opmode_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module opmode_host_model (
  input wire logic core_clk,
  input wire logic [opmode_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [opmode_pkg::ADDR_W-1:0] paddr,
  output logic [opmode_pkg::DATA_W-1:0] pwdata,
  output opmode_pkg::pins_s pins
);
  import opmode_pkg::*;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    pins = 11'h0;
  end
  // callers move pins only while no transfer is in flight, never active straight to limp
  task automatic set_pins(input pins_s p);
    pins <= p;
  endtask
  // bounded wait: a slave that never answers must not hang the run
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic err, output logic ok);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    rd = prdata;
    err = pslverr;
    ok = (pready === 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

/* dv/operation_mode_controller_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module operation_mode_controller_tb_top;
  import opmode_pkg::*;
  typedef struct packed {logic w; logic [1:0] d; mode_e m; logic [3:0] ch;} row_s;
  logic core_clk, reset_n, psel, penable, pwrite, pready, pslverr, power_on, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] channel_out, open_load_test;
  supply_s supply;
  pins_s pins;
  mode_e op_mode;
  int n_mismatch = 0;
  int samples_checked = 0;
  row_s rows [7] = '{
    '{1'b1, 2'h0, ST_IDLE, 4'h0},
    '{1'b1, 2'h1, ST_ACTIVE, 4'h4},
    '{1'b1, 2'h2, ST_ACTIVE, 4'h8},
    '{1'b1, 2'h0, ST_IDLE, 4'h0},
    '{1'b0, 2'h1, ST_LIMP, 4'h4},
    '{1'b0, 2'h3, ST_LIMP, 4'hC},
    '{1'b0, 2'h0, ST_SLEEP, 4'h0}};
  opmode_host_model i_host (.core_clk(core_clk), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pins(pins));
  operation_mode_controller #(.LAT_CYC(3)) i_operation_mode_controller (
    .core_clk(core_clk), .reset_n(reset_n), .pins(pins), .supply(supply), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .channel_out(channel_out),
    .open_load_test(open_load_test), .op_mode(op_mode), .power_on(power_on));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic wrap_up();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic pin(input logic w, input logic [1:0] d, input logic [3:0] f);
    i_host.set_pins({w, d, f, 4'h5});
  endtask
  task automatic wait_mode(input mode_e m);
    int n;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (op_mode !== m && n < 80);
    check(op_mode, m);
    if (op_mode !== m) wrap_up();
    @(posedge core_clk);
  endtask
  // inputs need sync plus mode update before the drive settles
  task automatic sample_ch(input logic [3:0] exp);
    repeat (4) @(negedge core_clk);
    check(channel_out, exp);
    @(posedge core_clk);
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic ok;
    i_host.xfer(w, a, d, r, e, ok);
    if (!ok) begin
      n_mismatch++;
      wrap_up();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(r, exp);
  endtask
  initial begin
    reset_n = 1'b0;
    supply = 4'h6;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    check(op_mode, ST_SLEEP);
    check(power_on, 1'b0);
    for (int i = 0; i < 7; i++) begin
      pin(rows[i].w, rows[i].d, 4'h0);
      wait_mode(rows[i].m);
      sample_ch(rows[i].ch);
    end
    pin(1'b1, 2'h0, 4'h0);
    wait_mode(ST_IDLE);
    check(power_on, 1'b1);
    xfer(1'b0, 8'h20, 32'h0);
    check(e, 1'b1);
    rd(OFF_MAP0, 32'h4);
    xfer(1'b1, OFF_HWCR, 32'h1);
    xfer(1'b1, OFF_OUT, 32'h1);
    wait_mode(ST_ACTIVE);
    sample_ch(4'h1);
    xfer(1'b1, OFF_OUT, 32'h0);
    xfer(1'b1, OFF_DIAG, 32'h3);
    check(open_load_test, 4'h3);
    repeat (6) @(posedge core_clk);
    check(op_mode, ST_ACTIVE);
    supply <= 4'h4;
    wait_mode(ST_IDLE);
    supply <= 4'h6;
    repeat (4) @(posedge core_clk);
    rd(OFF_HWCR, 32'h0);
    // idle keeps the programmed value but runs no open-load test
    xfer(1'b1, OFF_DIAG, 32'h3);
    check(open_load_test, 4'h0);
    rd(OFF_DIAG, 32'h3);
    xfer(1'b1, OFF_MAP1, 32'h3);
    xfer(1'b1, OFF_HWCR, 32'h2);
    rd(OFF_MAP1, 32'h8);
    xfer(1'b1, OFF_MAP0, 32'h0);
    xfer(1'b1, OFF_MAP1, 32'h0);
    pin(1'b1, 2'h1, 4'h1);
    wait_mode(ST_ACTIVE);
    sample_ch(4'h0);
    pin(1'b1, 2'h0, 4'h0);
    wait_mode(ST_IDLE);
    rd(OFF_ERR, 32'h1);
    // clear the unmapped-access error so the limp read sees only the entry flag
    rd(OFF_STAT, 32'h10);
    pin(1'b0, 2'h1, 4'h0);
    wait_mode(ST_LIMP);
    rd(OFF_STAT, 32'h1D);
    rd(OFF_STAT, 32'hD);
    rd(OFF_ERR, 32'h1);
    rd(OFF_OSM, 32'h5);
    xfer(1'b1, OFF_OUT, 32'hF);
    rd(OFF_OUT, 32'h0);
    xfer(1'b1, OFF_DIAG, 32'hF);
    rd(OFF_DIAG, 32'h0);
    rd(OFF_MAP0, 32'h4);
    check(open_load_test, 4'h0);
    pin(1'b0, 2'h0, 4'h0);
    wait_mode(ST_SLEEP);
    rd(OFF_OUT, 32'h0);
    check(power_on, 1'b0);
    wrap_up();
  end
endmodule
`default_nettype wire
